//--- src/cocb_option_bank.sv
// How it works
// - low power on battery: hot indicator, monitor buffers, comparator all off
// - otherwise those outputs follow their own enable inputs
// - watchdog field: 00 off, 01 44 s, 10 88 s, 11 175 s default
// - no limit register write within period forces charge current to zero
// - next write to voltage or current register restarts the watchdog
// - auto disable set and battery present rising clears regulation enable
// - overvoltage sets sticky bit, switches off; host writes 0 or unplug clears
// - audio limit bit holds switching at or above 40 kHz
// - frequency field 600k/800k/1M/1.2M, default set by variant
// - input overcurrent bit enables trip at 300 percent, default off
// - low side threshold 170 mV or 290 mV, default 290 mV
// - battery_discharge_calibration_mode bit stops buck, keeps input switches on, battery discharges
// - clearing battery_discharge_calibration_mode restarts buck; battery_discharge_calibration_mode off at power on
// - input gain 40x or 80x, discharge gain 8x or 16x
// - regulation enable bit turns input loop on or off, default on
// - inhibit bit blocks charging, default allowed
`timescale 1ns/10ps
`default_nettype none

module cocb_option_bank #(
  parameter logic [1:0]  FREQ_DEFAULT = cocb_pkg::FREQ_800K,
  parameter int unsigned TICK_CYCLES  = cocb_pkg::TICK_CYCLES
) (
  input  wire logic           clk,              // system clock
  input  wire logic           srst,             // sync reset, active high
  input  wire logic [7:0]     reg_addr,         // register address
  input  wire logic           reg_wr,           // write strobe, one cycle
  input  wire logic [15:0]    reg_wr_data,      // write word
  output logic      [15:0]    reg_rd_data,      // read word, registered
  input  wire logic           hot_ind_cfg_en,   // hot indicator own enable
  input  wire logic           batt_mon_cfg_en,  // discharge monitor enable
  input  wire logic           pwr_mon_cfg_en,   // power monitor enable
  input  wire logic           cmp_cfg_en,       // comparator own enable
  input  wire logic           sys_ovp_pin,      // overvoltage detect, async
  input  wire logic           adapter_pin,      // adapter present, async
  input  wire logic           battery_present_pin, // battery present, async
  input  wire logic           battery_only_pin, // battery-only supply, async
  output logic                charge_current_zero, // force current to 0
  output var cocb_pkg::cocb_ctrl_s ctrl         // decoded controls
);

  localparam logic [15:0] RESET_VAL =
    cocb_pkg::RESET_BASE | {6'h00, FREQ_DEFAULT, 8'h00};

  logic [15:0]                    reg_r;
  logic [15:0]                    reg_nxt;
  logic [cocb_pkg::NUM_PINS-1:0]  sync1_r;
  logic [cocb_pkg::NUM_PINS-1:0]  sync2_r;
  logic [cocb_pkg::NUM_PINS-1:0]  prev_r;
  logic [2:0]                     fill_r;
  logic                           wr_hit;
  logic                           kick;
  logic                           wd_expire;
  logic                           ovp_now;
  logic                           adapter_fall;
  logic                           bat_rise;
  logic                           bat_only;
  logic                           low_pwr_gate;
  cocb_pkg::cocb_ctrl_s           ctrl_nxt;

  // two-stage synchronisers plus edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
      fill_r  <= '0;
    end else begin
      sync1_r <= {battery_only_pin, battery_present_pin,
                  adapter_pin, sys_ovp_pin};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      fill_r  <= {fill_r[1:0], 1'b1};
    end
  end

  assign ovp_now      = sync2_r[cocb_pkg::PIN_OVP];
  // no edges until the history holds real pin samples after reset
  assign adapter_fall = fill_r[2] && prev_r[cocb_pkg::PIN_ADAPTER] &&
                        !sync2_r[cocb_pkg::PIN_ADAPTER];
  assign bat_rise     = fill_r[2] && !prev_r[cocb_pkg::PIN_BATTERY_PRESENT_PIN] &&
                        sync2_r[cocb_pkg::PIN_BATTERY_PRESENT_PIN];
  assign bat_only     = sync2_r[cocb_pkg::PIN_BATONLY];

  assign wr_hit = reg_wr && (reg_addr == cocb_pkg::REG_ADDR_OPTION0);
  assign kick   = reg_wr && ((reg_addr == cocb_pkg::REG_ADDR_CHG_CURR) ||
                             (reg_addr == cocb_pkg::REG_ADDR_CHG_VOLT));

  // register next value; hardware events override host writes
  always_comb begin
    reg_nxt = reg_r;
    if (wr_hit) begin
      reg_nxt = reg_wr_data;
      reg_nxt[cocb_pkg::B_OVP] = reg_r[cocb_pkg::B_OVP] &&
                                 reg_wr_data[cocb_pkg::B_OVP];
    end
    if (adapter_fall) begin
      reg_nxt[cocb_pkg::B_OVP] = 1'b0;
    end
    if (ovp_now) begin
      reg_nxt[cocb_pkg::B_OVP] = 1'b1;
    end
    if (bat_rise && reg_r[cocb_pkg::B_AUTO_DIS]) begin
      reg_nxt[cocb_pkg::B_REG_EN] = 1'b0;
    end
    reg_nxt[cocb_pkg::B_RSVD] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_r <= RESET_VAL;
    end else begin
      reg_r <= reg_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rd_data <= 16'h0000;
    end else if (reg_addr == cocb_pkg::REG_ADDR_OPTION0) begin
      reg_rd_data <= reg_r;
    end else begin
      reg_rd_data <= 16'h0000;
    end
  end

  cocb_watchdog #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_watchdog (
    .clk    (clk),
    .srst   (srst),
    .sel    (reg_r[cocb_pkg::B_WD_HI:cocb_pkg::B_WD_LO]),
    .kick   (kick),
    .expire (wd_expire)
  );

  // expiry zeroes the current setting only; converter keeps running
  always_ff @(posedge clk) begin
    if (srst) begin
      charge_current_zero <= 1'b0;
    end else begin
      charge_current_zero <= wd_expire;
    end
  end

  assign low_pwr_gate = reg_r[cocb_pkg::B_LOW_POWER] && bat_only;

  always_comb begin
    ctrl_nxt.hot_indicator_en   = hot_ind_cfg_en  && !low_pwr_gate;
    ctrl_nxt.batt_mon_buf_en    = batt_mon_cfg_en && !low_pwr_gate;
    ctrl_nxt.pwr_mon_buf_en     = pwr_mon_cfg_en  && !low_pwr_gate;
    ctrl_nxt.comparator_en      = cmp_cfg_en      && !low_pwr_gate;
    ctrl_nxt.audio_limit_en     = reg_r[cocb_pkg::B_AUDIO];
    ctrl_nxt.sw_freq_sel        =
      reg_r[cocb_pkg::B_FREQ_HI:cocb_pkg::B_FREQ_LO];
    ctrl_nxt.input_oc_en        = reg_r[cocb_pkg::B_IN_OC];
    ctrl_nxt.ls_oc_high_thr     = reg_r[cocb_pkg::B_LS_OC];
    ctrl_nxt.buck_run           = !reg_r[cocb_pkg::B_BATTERY_DISCHARGE_CALIBRATION_MODE];
    ctrl_nxt.adapter_switch_on  = !reg_r[cocb_pkg::B_OVP];
    ctrl_nxt.reverse_blocking_switch_on = !reg_r[cocb_pkg::B_OVP];
    ctrl_nxt.battery_discharge_on = reg_r[cocb_pkg::B_BATTERY_DISCHARGE_CALIBRATION_MODE];
    ctrl_nxt.input_gain_80x     = reg_r[cocb_pkg::B_IN_GAIN];
    ctrl_nxt.discharge_gain_16x = reg_r[cocb_pkg::B_DIS_GAIN];
    ctrl_nxt.input_regulation_en = reg_r[cocb_pkg::B_REG_EN];
    ctrl_nxt.charge_allowed     = !reg_r[cocb_pkg::B_INHIBIT] &&
                                  !reg_r[cocb_pkg::B_BATTERY_DISCHARGE_CALIBRATION_MODE];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= '0;
    end else begin
      ctrl <= ctrl_nxt;
    end
  end

  // checks
  property p_low_power_off;
    @(posedge clk) disable iff (srst)
    (reg_r[cocb_pkg::B_LOW_POWER] && bat_only) |=>
      (!ctrl.hot_indicator_en && !ctrl.batt_mon_buf_en &&
       !ctrl.pwr_mon_buf_en && !ctrl.comparator_en);
  endproperty
  a_low_power_off: assert property (p_low_power_off)
    else $error("low power did not gate monitor outputs");

  property p_perf_follow;
    @(posedge clk) disable iff (srst)
    (!reg_r[cocb_pkg::B_LOW_POWER] || !bat_only) |=>
      (ctrl.hot_indicator_en == $past(hot_ind_cfg_en)) &&
      (ctrl.batt_mon_buf_en == $past(batt_mon_cfg_en)) &&
      (ctrl.pwr_mon_buf_en == $past(pwr_mon_cfg_en)) &&
      (ctrl.comparator_en == $past(cmp_cfg_en));
  endproperty
  a_perf_follow: assert property (p_perf_follow)
    else $error("monitor enables did not follow own settings");

  property p_wd_off;
    @(posedge clk) disable iff (srst)
    (reg_r[cocb_pkg::B_WD_HI:cocb_pkg::B_WD_LO] == cocb_pkg::WD_OFF)[*3]
      |-> !charge_current_zero;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("disabled watchdog produced an expiry");

  property p_wd_zero_cause;
    @(posedge clk) disable iff (srst)
    $rose(charge_current_zero) |->
      $past(reg_r[cocb_pkg::B_WD_HI:cocb_pkg::B_WD_LO], 2) != 2'h0;
  endproperty
  a_wd_zero_cause: assert property (p_wd_zero_cause)
    else $error("current zeroed with watchdog off");

  property p_kick_restart;
    @(posedge clk) disable iff (srst)
    kick |-> ##2 !charge_current_zero;
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("expiry right after a limit register write");

  property p_auto_disable;
    @(posedge clk) disable iff (srst)
    (bat_rise && reg_r[cocb_pkg::B_AUTO_DIS]) |=>
      !reg_r[cocb_pkg::B_REG_EN] ##1 !ctrl.input_regulation_en;
  endproperty
  a_auto_disable: assert property (p_auto_disable)
    else $error("auto disable did not clear regulation enable");

  property p_ovp_latch;
    @(posedge clk) disable iff (srst)
    ovp_now |=> reg_r[cocb_pkg::B_OVP] ##1
      (!ctrl.adapter_switch_on && !ctrl.reverse_blocking_switch_on);
  endproperty
  a_ovp_latch: assert property (p_ovp_latch)
    else $error("overvoltage did not latch switches off");

  property p_battery_discharge_calibration_mode;
    @(posedge clk) disable iff (srst)
    (reg_r[cocb_pkg::B_BATTERY_DISCHARGE_CALIBRATION_MODE] && !reg_r[cocb_pkg::B_OVP]) |=>
      (!ctrl.buck_run && ctrl.battery_discharge_on &&
       ctrl.adapter_switch_on && !ctrl.charge_allowed);
  endproperty
  a_battery_discharge_calibration_mode: assert property (p_battery_discharge_calibration_mode)
    else $error("battery_discharge_calibration_mode mode outputs wrong");

  property p_battery_discharge_calibration_mode_exit;
    @(posedge clk) disable iff (srst)
    $fell(reg_r[cocb_pkg::B_BATTERY_DISCHARGE_CALIBRATION_MODE]) |=> ctrl.buck_run;
  endproperty
  a_battery_discharge_calibration_mode_exit: assert property (p_battery_discharge_calibration_mode_exit)
    else $error("buck did not restart after battery_discharge_calibration_mode");

  property p_inhibit;
    @(posedge clk) disable iff (srst)
    reg_r[cocb_pkg::B_INHIBIT] |=> !ctrl.charge_allowed;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("charging allowed while inhibited");

  property p_rsvd_read;
    @(posedge clk) disable iff (srst)
    (reg_addr == cocb_pkg::REG_ADDR_OPTION0) |=>
      reg_rd_data[cocb_pkg::B_RSVD];
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved bit read as zero");

  property p_word_write;
    @(posedge clk) disable iff (srst)
    wr_hit |=> ##1 (ctrl.sw_freq_sel == $past(reg_wr_data[9:8], 2)) &&
      (ctrl.input_gain_80x == $past(reg_wr_data[cocb_pkg::B_IN_GAIN], 2)) &&
      (ctrl.ls_oc_high_thr == $past(reg_wr_data[cocb_pkg::B_LS_OC], 2));
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("written fields did not take effect together");

  property p_ovp_no_set;
    @(posedge clk) disable iff (srst)
    (wr_hit && !reg_r[cocb_pkg::B_OVP] && !ovp_now) |=>
      !reg_r[cocb_pkg::B_OVP];
  endproperty
  a_ovp_no_set: assert property (p_ovp_no_set)
    else $error("host write set the overvoltage bit");

  property p_rd_other;
    @(posedge clk) disable iff (srst)
    (reg_addr != cocb_pkg::REG_ADDR_OPTION0) |=> (reg_rd_data == 16'h0000);
  endproperty
  a_rd_other: assert property (p_rd_other)
    else $error("other address returned nonzero read data");

  c_expire: cover property (@(posedge clk) disable iff (srst)
    $rose(charge_current_zero));
  c_ovp: cover property (@(posedge clk) disable iff (srst)
    $rose(reg_r[cocb_pkg::B_OVP]));
  c_auto: cover property (@(posedge clk) disable iff (srst)
    bat_rise && reg_r[cocb_pkg::B_AUTO_DIS]);
  c_battery_discharge_calibration_mode: cover property (@(posedge clk) disable iff (srst)
    $rose(ctrl.battery_discharge_on));
  c_reenable: cover property (@(posedge clk) disable iff (srst)
    $rose(ctrl.input_regulation_en));

endmodule // cocb_option_bank

`default_nettype wire

//--- src/cocb_pkg.sv
package cocb_pkg;

  // register map
  localparam logic [7:0] REG_ADDR_OPTION0   = 8'h12;
  localparam logic [7:0] REG_ADDR_CHG_CURR  = 8'h14;
  localparam logic [7:0] REG_ADDR_CHG_VOLT  = 8'h15;

  // field positions
  localparam int B_LOW_POWER = 15;
  localparam int B_WD_HI     = 14;
  localparam int B_WD_LO     = 13;
  localparam int B_AUTO_DIS  = 12;
  localparam int B_OVP       = 11;
  localparam int B_AUDIO     = 10;
  localparam int B_FREQ_HI   = 9;
  localparam int B_FREQ_LO   = 8;
  localparam int B_IN_OC     = 7;
  localparam int B_LS_OC     = 6;
  localparam int B_BATTERY_DISCHARGE_CALIBRATION_MODE     = 5;
  localparam int B_IN_GAIN   = 4;
  localparam int B_DIS_GAIN  = 3;
  localparam int B_RSVD      = 2;
  localparam int B_REG_EN    = 1;
  localparam int B_INHIBIT   = 0;

  // reset value without the frequency field
  localparam logic [15:0] RESET_BASE   = 16'hE04E;
  localparam logic [1:0]  FREQ_800K    = 2'h1;
  localparam logic [1:0]  FREQ_1M2     = 2'h3;

  // watchdog selection codes and periods
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [1:0] WD_44  = 2'h1;
  localparam logic [1:0] WD_88  = 2'h2;
  localparam logic [1:0] WD_175 = 2'h3;
  localparam int WD_44_S  = 44;
  localparam int WD_88_S  = 88;
  localparam int WD_175_S = 175;

  // watchdog counts in 1 ms ticks
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_S    = 1000;
  localparam int WD_CNT_W       = 18;
  localparam logic [WD_CNT_W-1:0] WD_44_TICKS  =
    WD_CNT_W'(WD_44_S * TICKS_PER_S);
  localparam logic [WD_CNT_W-1:0] WD_88_TICKS  =
    WD_CNT_W'(WD_88_S * TICKS_PER_S);
  localparam logic [WD_CNT_W-1:0] WD_175_TICKS =
    WD_CNT_W'(WD_175_S * TICKS_PER_S);

  // synchronised pin indices
  localparam int PIN_OVP     = 0;
  localparam int PIN_ADAPTER = 1;
  localparam int PIN_BATTERY_PRESENT_PIN = 2;
  localparam int PIN_BATONLY = 3;
  localparam int NUM_PINS    = 4;

  typedef enum logic [1:0] {
    COCB_WD_IDLE    = 2'b00,
    COCB_WD_RUN     = 2'b01,
    COCB_WD_EXPIRED = 2'b11
  } cocb_wd_state_e;

  typedef struct packed {
    logic       hot_indicator_en;
    logic       batt_mon_buf_en;
    logic       pwr_mon_buf_en;
    logic       comparator_en;
    logic       audio_limit_en;
    logic [1:0] sw_freq_sel;
    logic       input_oc_en;
    logic       ls_oc_high_thr;
    logic       buck_run;
    logic       adapter_switch_on;
    logic       reverse_blocking_switch_on;
    logic       battery_discharge_on;
    logic       input_gain_80x;
    logic       discharge_gain_16x;
    logic       input_regulation_en;
    logic       charge_allowed;
  } cocb_ctrl_s;

endpackage

//--- src/cocb_watchdog.sv
`timescale 1ns/10ps
`default_nettype none

module cocb_watchdog #(
  parameter int unsigned TICK_CYCLES = cocb_pkg::TICK_CYCLES
) (
  input  wire logic       clk,      // system clock
  input  wire logic       srst,     // sync reset, active high
  input  wire logic [1:0] sel,      // period selection
  input  wire logic       kick,     // limit register write
  output logic            expire    // one-cycle expiry pulse
);

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [TW-1:0]                  div_r;
  logic                           tick;
  logic [cocb_pkg::WD_CNT_W-1:0]  cnt_r;
  logic [cocb_pkg::WD_CNT_W-1:0]  limit;
  cocb_pkg::cocb_wd_state_e       state_r;
  logic                           done;

  assign tick = (div_r == TICK_LAST);

  always_ff @(posedge clk) begin
    if (srst || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + TW'(1);
    end
  end

  always_comb begin
    case (sel)
      cocb_pkg::WD_44: limit = cocb_pkg::WD_44_TICKS;
      cocb_pkg::WD_88: limit = cocb_pkg::WD_88_TICKS;
      default:         limit = cocb_pkg::WD_175_TICKS;
    endcase
  end

  assign done = tick && (cnt_r >= limit - cocb_pkg::WD_CNT_W'(1));

  // counting and expiry; a kick always restarts the period
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= cocb_pkg::COCB_WD_RUN;
      cnt_r   <= '0;
      expire  <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (sel == cocb_pkg::WD_OFF) begin
        state_r <= cocb_pkg::COCB_WD_IDLE;
        cnt_r   <= '0;
      end else if (kick) begin
        state_r <= cocb_pkg::COCB_WD_RUN;
        cnt_r   <= '0;
      end else begin
        case (state_r)
          cocb_pkg::COCB_WD_IDLE: begin
            state_r <= cocb_pkg::COCB_WD_RUN;
            cnt_r   <= '0;
          end
          cocb_pkg::COCB_WD_RUN: begin
            if (done) begin
              state_r <= cocb_pkg::COCB_WD_EXPIRED;
              expire  <= 1'b1;
            end else if (tick) begin
              cnt_r <= cnt_r + cocb_pkg::WD_CNT_W'(1);
            end
          end
          default: begin
            state_r <= cocb_pkg::COCB_WD_EXPIRED;
          end
        endcase
      end
    end
  end

endmodule // cocb_watchdog

`default_nettype wire

//--- tb/cocb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module cocb_host_model (
  input  wire logic        clk,          // system clock
  output logic      [7:0]  reg_addr,     // register address
  output logic             reg_wr,       // write strobe
  output logic      [15:0] reg_wr_data,  // write word
  input  wire logic [15:0] reg_rd_data   // read word
);
  initial begin
    reg_addr    = cocb_pkg::REG_ADDR_OPTION0;
    reg_wr      = 1'b0;
    reg_wr_data = 16'h0000;
  end

  // one-cycle strobe; released data is scrambled, not held
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr    = a;
    reg_wr_data = d;
    reg_wr      = 1'b1;
    @(negedge clk);
    reg_wr      = 1'b0;
    reg_wr_data = ~d;
    reg_addr    = cocb_pkg::REG_ADDR_OPTION0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rd_data;
  endtask

  // inhibit cleared first, then a nonzero current
  task automatic charge_start(input logic [15:0] opt,
                              input logic [15:0] cur);
    wr(cocb_pkg::REG_ADDR_OPTION0, opt & 16'hFFFE);
    wr(cocb_pkg::REG_ADDR_CHG_CURR, cur);
  endtask
endmodule // cocb_host_model

`default_nettype wire

//--- tb/charger_option_control_bank_bench.sv
`timescale 1ns/10ps
`default_nettype none

module charger_option_control_bank_bench;
  typedef struct packed {
    logic [15:0] w;
    logic        bo;
    logic [3:0]  cfg;
    logic [15:0] rd;
  } cocb_row_s;

  logic                clk;
  logic                srst;
  logic [7:0]          reg_addr;
  logic                reg_wr;
  logic [15:0]         reg_wr_data;
  logic [15:0]         reg_rd_data;
  logic [3:0]          cfg;
  logic                ovp;
  logic                adapter;
  logic                bpres;
  logic                bonly;
  logic                ccz;
  cocb_pkg::cocb_ctrl_s ctrl;
  int                  errors;
  int                  n_checks;
  int                  n;
  int                  k;
  logic [15:0]         d16;
  cocb_row_s           rows [5];

  cocb_option_bank #(.FREQ_DEFAULT(2'h1), .TICK_CYCLES(1)) uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .hot_ind_cfg_en(cfg[3]), .batt_mon_cfg_en(cfg[2]),
    .pwr_mon_cfg_en(cfg[1]), .cmp_cfg_en(cfg[0]), .sys_ovp_pin(ovp),
    .adapter_pin(adapter), .battery_present_pin(bpres),
    .battery_only_pin(bonly), .charge_current_zero(ccz), .ctrl(ctrl)
  );

  cocb_host_model host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic cocb_pkg::cocb_ctrl_s exp_ctrl(
      input logic [15:0] w, input logic bo, input logic [3:0] c);
    cocb_pkg::cocb_ctrl_s e;
    logic on;
    on = !(w[15] && bo);
    e.hot_indicator_en           = c[3] && on;
    e.batt_mon_buf_en            = c[2] && on;
    e.pwr_mon_buf_en             = c[1] && on;
    e.comparator_en              = c[0] && on;
    e.audio_limit_en             = w[10];
    e.sw_freq_sel                = w[9:8];
    e.input_oc_en                = w[7];
    e.ls_oc_high_thr             = w[6];
    e.buck_run                   = !w[5];
    e.adapter_switch_on          = !w[11];
    e.reverse_blocking_switch_on = !w[11];
    e.battery_discharge_on       = w[5];
    e.input_gain_80x             = w[4];
    e.discharge_gain_16x         = w[3];
    e.input_regulation_en        = w[1];
    e.charge_allowed             = !w[0] && !w[5];
    return e;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // readback and decoded controls against the expected word
  task automatic check_reg(input logic [15:0] w);
    logic [15:0] d;
    host.rd(cocb_pkg::REG_ADDR_OPTION0, d);
    chk("readback", 32'(d), 32'(w));
    chk("ctrl", 32'(ctrl), 32'(exp_ctrl(w, bonly, cfg)));
  endtask

  task automatic wr_opt(input logic [15:0] w);
    host.wr(cocb_pkg::REG_ADDR_OPTION0, w);
    repeat (2) @(negedge clk);
  endtask

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  // kick-to-pulse distance in cycles, bounded
  task automatic wait_pulse(output int cnt);
    cnt = 0;
    while (ccz !== 1'b1 && cnt < 50000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 50000) begin
      errors++;
      summarize();
    end
  endtask

  // pulses seen over a fixed number of cycles
  task automatic count_pulses(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (ccz === 1'b1)
        cnt++;
    end
  endtask

  initial begin
    errors   = 0;
    n_checks = 0;
    srst     = 1'b1;
    cfg      = 4'hF;
    ovp      = 1'b0;
    adapter  = 1'b1;
    bpres    = 1'b0;
    bonly    = 1'b0;
    rows = '{'{16'h0000, 1'b0, 4'hF, 16'h0004},
             '{16'hFFFF, 1'b1, 4'hF, 16'hF7FF},
             '{16'hFFFF, 1'b0, 4'hA, 16'hF7FF},
             '{16'h5A5A, 1'b1, 4'h5, 16'h525E},
             '{16'hA5A1, 1'b1, 4'hF, 16'hA5A5}};
    repeat (6) @(negedge clk);
    srst = 1'b0;
    check_reg(16'hE14E);
    foreach (rows[i]) begin
      @(negedge clk);
      bonly = rows[i].bo;
      cfg   = rows[i].cfg;
      wr_opt(rows[i].w);
      check_reg(rows[i].rd);
    end
    bonly = 1'b0;
    cfg   = 4'hF;
    wr_opt(16'h1002);
    bpres = 1'b1;
    settle();
    check_reg(16'h1004);
    wr_opt(16'h1006);
    check_reg(16'h1006);
    bpres = 1'b0;
    wr_opt(16'h0002);
    bpres = 1'b1;
    settle();
    check_reg(16'h0006);
    ovp = 1'b1;
    settle();
    check_reg(16'h0806);
    wr_opt(16'h0000);
    check_reg(16'h0804);
    ovp = 1'b0;
    settle();
    check_reg(16'h0804);
    wr_opt(16'h0000);
    check_reg(16'h0004);
    ovp = 1'b1;
    settle();
    ovp = 1'b0;
    adapter = 1'b0;
    settle();
    check_reg(16'h0004);
    adapter = 1'b1;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk("rst_rd", 32'(reg_rd_data), 32'h0000_0000);
    chk("rst_ctrl", 32'(ctrl), 32'h0000_0000);
    chk("rst_ccz", 32'(ccz), 32'h0000_0000);
    srst = 1'b0;
    check_reg(16'hE14E);
    host.rd(cocb_pkg::REG_ADDR_CHG_CURR, d16);
    chk("rd_other", 32'(d16), 32'h0000_0000);
    host.charge_start(16'hA14F, 16'h0100);
    wait_pulse(n);
    chk("wd_44", 32'(n >= 43995 && n <= 44010), 32'h0000_0001);
    count_pulses(200, k);
    chk("wd_once", 32'(k), 32'h0000_0000);
    host.wr(cocb_pkg::REG_ADDR_OPTION0, 16'hC14E);
    host.wr(cocb_pkg::REG_ADDR_CHG_VOLT, 16'h1000);
    count_pulses(44010, k);
    chk("wd_88_quiet", 32'(k), 32'h0000_0000);
    host.wr(cocb_pkg::REG_ADDR_OPTION0, 16'hE14E);
    count_pulses(10, k);
    chk("wd_175_quiet", 32'(k), 32'h0000_0000);
    host.wr(cocb_pkg::REG_ADDR_OPTION0, 16'hA14E);
    wait_pulse(n);
    chk("wd_rearm", 32'(n <= 4), 32'h0000_0001);
    summarize();
  end
endmodule // charger_option_control_bank_bench

`default_nettype wire
